/* core/uart_flow_pkg.sv */
package uart_flow_pkg;
  // =========================================================
  // register indices
  localparam logic [3:0] REG_IER = 4'h0;
  localparam logic [3:0] REG_ISR = 4'h1;
  localparam logic [3:0] REG_LCR = 4'h2;
  localparam logic [3:0] REG_MCR = 4'h3;
  localparam logic [3:0] REG_LSR = 4'h4;
  localparam logic [3:0] REG_MSR = 4'h5;
  localparam logic [3:0] REG_SPR = 4'h6;
  localparam logic [3:0] REG_EFR = 4'h7;
  localparam logic [3:0] REG_SW_FLOW_RESUME_CHAR_1 = 4'h8;
  localparam logic [3:0] REG_SW_FLOW_RESUME_CHAR_2 = 4'h9;
  localparam logic [3:0] REG_SW_FLOW_PAUSE_CHAR_1 = 4'hA;
  localparam logic [3:0] REG_SW_FLOW_PAUSE_CHAR_2 = 4'hB;
  localparam logic [3:0] REG_DLL = 4'hC;
  localparam logic [3:0] REG_DLM = 4'hD;
  localparam logic [3:0] REG_TRIG = 4'hE;
  localparam logic [3:0] REG_RXDATA = 4'hF;
  // =========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SPR = 8'hFF;
  localparam logic [7:0] RST_DLL = 8'h01;
  localparam logic [7:0] RST_DLM = 8'h00;
  // =========================================================
  // field positions
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int EFR_ENH = 4;
  localparam int IER_RX = 0;
  localparam int IER_SPECIAL = 5;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_MULTIDROP = 6;
  localparam int ISR_SPECIAL = 4;
  localparam int ISR_PAUSE = 5;
  localparam int LSR_DR = 0;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int MODEM_CTS = 0;
  localparam logic [1:0] FLOW_NONE = 2'b00;
  localparam logic [1:0] FLOW_PAIR2 = 2'b01;
  localparam logic [1:0] FLOW_PAIR1 = 2'b10;
  localparam logic [2:0] ISR_ID_RX = 3'b010;
  localparam logic [2:0] ISR_ID_NONE = 3'b000;
endpackage

/* core/flow_fifo.sv */
`timescale 1ns/1ps
module flow_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [LW-1:0] next_level;
  logic full;
  logic next_full;
  logic push, pop;

  assign push = in_valid && !full;
  assign pop = (level != '0) && out_ready;
  // ready is the registered one so it leaves the block straight from a flop
  assign full = !in_ready;
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    if (push) begin
      next_wr_ptr = (int'(wr_ptr) == DEPTH - 1) ? '0 : AW'(int'(wr_ptr) + 1);
    end
    if (pop) begin
      next_rd_ptr = (int'(rd_ptr) == DEPTH - 1) ? '0 : AW'(int'(rd_ptr) + 1);
    end
    if (push && !pop) begin
      next_level = LW'(int'(level) + 1);
    end else if (pop && !push) begin
      next_level = LW'(int'(level) - 1);
    end
    // full is kept as a flop so the ready seen upstream is glitch free
    next_full = (int'(next_level) == DEPTH);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
      in_ready <= !next_full;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // flow_fifo

/* core/uart_flow_ctrl.sv */
`timescale 1ns/1ps
module uart_flow_ctrl
  import uart_flow_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int HYST = 1,
  parameter int LW = $clog2(FIFO_DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic power_on,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_addr_flag,
  output logic rx_ready,
  input wire logic tx_serial,
  input wire logic tx_hold_empty,
  input wire logic tx_shift_empty,
  output logic tx_allow,
  output logic tx_out,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic rts_n,
  output logic dtr_n,
  output logic int_out,
  output logic int_oe_n,
  output logic [15:0] divisor
);
  // =========================================================
  // control registers
  logic [7:0] interrupt_enable_reg, lcr, mcr, scratch_reg, enhanced_feature_control, sw_flow_resume_char_1, sw_flow_resume_char_2, sw_flow_pause_char_1, sw_flow_pause_char_2, rx_trig;
  logic [7:0] next_ier, next_lcr, next_mcr, next_spr, next_efr;
  logic [7:0] next_sw_flow_resume_char_1, next_sw_flow_resume_char_2, next_sw_flow_pause_char_1, next_sw_flow_pause_char_2, next_rx_trig;
  logic [7:0] dll, divisor_high_byte, next_dll, next_dlm;
  logic special_flag, pause_flag, next_special_flag, next_pause_flag;
  logic sw_paused, next_sw_paused;
  logic addr_match, next_addr_match;
  logic rts_hold, next_rts_hold;
  logic thre_q, temt_q;
  logic [7:0] next_rdata;
  logic next_rts_n, next_tx_allow, next_int_out, next_int_oe_n;

  // =========================================================
  // pin synchronisers for modem inputs
  logic [3:0] modem_meta, modem_sync;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modem_meta <= '1;
      modem_sync <= '1;
    end else begin
      modem_meta <= {dcd_n, ri_n, dsr_n, cts_n};
      modem_sync <= modem_meta;
    end
  end

  // =========================================================
  // receive FIFO
  logic fifo_in_valid, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;
  logic [LW-1:0] fifo_level;

  flow_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .LW(LW)
  ) u_rx_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // =========================================================
  // receive character classification
  logic rx_take, wr_en, rd_en, enh_ok;
  logic hit_on1, hit_on2, hit_off1, hit_off2;
  logic flow_on, flow_off, special_hit, store_char, md_on;
  logic [1:0] flow_mode;

  assign rx_take = rx_valid && rx_ready;
  assign flow_mode = enhanced_feature_control[1:0];
  // bit 0 of each stored char meets bit 0 of rx_data, the first serial bit
  assign hit_on1 = (rx_data == sw_flow_resume_char_1);
  assign hit_on2 = (rx_data == sw_flow_resume_char_2);
  assign hit_off1 = (rx_data == sw_flow_pause_char_1);
  assign hit_off2 = (rx_data == sw_flow_pause_char_2);
  assign md_on = mcr[MCR_MULTIDROP];
  assign fifo_pop = rd_en && (reg_sel == REG_RXDATA) && fifo_out_valid;
  assign wr_en = reg_wr;
  assign rd_en = reg_rd;
  // enhanced bits only change while the enable bit is set
  assign enh_ok = enhanced_feature_control[EFR_ENH];

  always_comb begin
    flow_on = 1'b0;
    flow_off = 1'b0;
    unique case (flow_mode)
      FLOW_PAIR1: begin
        flow_on = hit_on1;
        flow_off = hit_off1;
      end
      FLOW_PAIR2: begin
        flow_on = hit_on2;
        flow_off = hit_off2;
      end
      FLOW_NONE: begin
        flow_on = 1'b0;
        flow_off = 1'b0;
      end
      default: begin
        // single characters of either pair are honoured
        flow_on = hit_on1 || hit_on2;
        flow_off = hit_off1 || hit_off2;
      end
    endcase
    special_hit = enhanced_feature_control[EFR_SPECIAL] && hit_off2;
    if (md_on && rx_addr_flag) begin
      store_char = 1'b0;
    end else if (md_on && !addr_match) begin
      store_char = 1'b0;
    end else if (special_hit && flow_mode != FLOW_PAIR2) begin
      store_char = 1'b1;
    end else begin
      store_char = !(flow_on || flow_off);
    end
  end

  assign fifo_in_valid = rx_take && store_char;

  // =========================================================
  // register writes and receive side state
  always_comb begin
    next_ier = interrupt_enable_reg;
    next_lcr = lcr;
    next_mcr = mcr;
    next_spr = scratch_reg;
    next_efr = enhanced_feature_control;
    next_sw_flow_resume_char_1 = sw_flow_resume_char_1;
    next_sw_flow_resume_char_2 = sw_flow_resume_char_2;
    next_sw_flow_pause_char_1 = sw_flow_pause_char_1;
    next_sw_flow_pause_char_2 = sw_flow_pause_char_2;
    next_rx_trig = rx_trig;
    next_sw_paused = sw_paused;
    next_addr_match = addr_match;
    next_special_flag = special_flag;
    next_pause_flag = pause_flag;
    if (wr_en) begin
      unique case (reg_sel)
        REG_IER: next_ier = enh_ok ? reg_wdata : {interrupt_enable_reg[7:4], reg_wdata[3:0]};
        REG_LCR: next_lcr = reg_wdata;
        REG_MCR: next_mcr = enh_ok ? reg_wdata : {mcr[7:5], reg_wdata[4:0]};
        REG_SPR: next_spr = reg_wdata;
        REG_EFR: next_efr = reg_wdata;
        REG_SW_FLOW_RESUME_CHAR_1: next_sw_flow_resume_char_1 = reg_wdata;
        REG_SW_FLOW_RESUME_CHAR_2: next_sw_flow_resume_char_2 = reg_wdata;
        REG_SW_FLOW_PAUSE_CHAR_1: next_sw_flow_pause_char_1 = reg_wdata;
        REG_SW_FLOW_PAUSE_CHAR_2: next_sw_flow_pause_char_2 = reg_wdata;
        REG_TRIG: next_rx_trig = reg_wdata;
        default: begin
          // status, line, modem and data slots ignore writes
        end
      endcase
    end
    // reading the status register acknowledges both character flags
    if (rd_en && reg_sel == REG_ISR) begin
      next_special_flag = 1'b0;
      next_pause_flag = 1'b0;
    end
    if (rx_take) begin
      if (md_on && rx_addr_flag) begin
        next_addr_match = hit_off2;
      end else begin
        if (flow_off) begin
          next_sw_paused = 1'b1;
          next_pause_flag = 1'b1;
        end else if (flow_on) begin
          next_sw_paused = 1'b0;
        end
        // in pair-2 mode the special flag needs its enable as well
        if (special_hit && (flow_mode != FLOW_PAIR2 || interrupt_enable_reg[IER_SPECIAL])) begin
          next_special_flag = 1'b1;
        end
      end
    end
    if (flow_mode == FLOW_NONE) begin
      next_sw_paused = 1'b0;
    end
  end

  // =========================================================
  // pins, interrupt and read data
  logic rx_trig_hit, pending;
  logic [7:0] isr_val, lsr_val, msr_val;
  logic [LW:0] lvl_ext;
  int upper_lvl, lower_lvl;

  assign lvl_ext = {1'b0, fifo_level};
  assign rx_trig_hit = (fifo_level != '0) && (8'(lvl_ext) >= rx_trig);
  assign pending = (interrupt_enable_reg[IER_RX] && rx_trig_hit)
                || (interrupt_enable_reg[IER_SPECIAL] && (special_flag || pause_flag));
  assign isr_val = {2'b00, pause_flag, special_flag,
                    rx_trig_hit ? ISR_ID_RX : ISR_ID_NONE, !pending};
  assign lsr_val = {1'b0, temt_q, thre_q, 4'h0, fifo_out_valid};
  // lower nibble holds no change history, so it reads zero
  assign msr_val = {~modem_sync, 4'h0};

  always_comb begin
    upper_lvl = int'(rx_trig) + HYST;
    lower_lvl = int'(rx_trig) - HYST;
    next_rts_hold = rts_hold;
    if (int'(fifo_level) >= upper_lvl) begin
      next_rts_hold = 1'b1;
    end else if (int'(fifo_level) < lower_lvl) begin
      next_rts_hold = 1'b0;
    end
    // auto control only acts once software has asserted the line
    if (enhanced_feature_control[EFR_AUTO_RTS] && mcr[MCR_RTS]) begin
      next_rts_n = rts_hold;
    end else begin
      next_rts_n = !mcr[MCR_RTS];
    end
    // a frame already under way finishes; only new starts are held
    next_tx_allow = !(enhanced_feature_control[EFR_AUTO_CTS] && modem_sync[MODEM_CTS])
                 && !sw_paused;
    next_int_out = pending;
    next_int_oe_n = !mcr[MCR_OUT2];
    unique case (reg_sel)
      REG_IER: next_rdata = interrupt_enable_reg;
      REG_ISR: next_rdata = isr_val;
      REG_LCR: next_rdata = lcr;
      REG_MCR: next_rdata = mcr;
      REG_LSR: next_rdata = lsr_val;
      REG_MSR: next_rdata = msr_val;
      REG_SPR: next_rdata = scratch_reg;
      REG_EFR: next_rdata = enhanced_feature_control;
      REG_SW_FLOW_RESUME_CHAR_1: next_rdata = sw_flow_resume_char_1;
      REG_SW_FLOW_RESUME_CHAR_2: next_rdata = sw_flow_resume_char_2;
      REG_SW_FLOW_PAUSE_CHAR_1: next_rdata = sw_flow_pause_char_1;
      REG_SW_FLOW_PAUSE_CHAR_2: next_rdata = sw_flow_pause_char_2;
      REG_DLL: next_rdata = dll;
      REG_DLM: next_rdata = divisor_high_byte;
      REG_TRIG: next_rdata = rx_trig;
      REG_RXDATA: next_rdata = fifo_out_valid ? fifo_out_data : RST_ZERO;
    endcase
    if (!rd_en) begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      interrupt_enable_reg <= RST_ZERO;
      lcr <= RST_ZERO;
      mcr <= RST_ZERO;
      scratch_reg <= RST_SPR;
      enhanced_feature_control <= RST_ZERO;
      sw_flow_resume_char_1 <= RST_ZERO;
      sw_flow_resume_char_2 <= RST_ZERO;
      sw_flow_pause_char_1 <= RST_ZERO;
      sw_flow_pause_char_2 <= RST_ZERO;
      rx_trig <= RST_ZERO;
      sw_paused <= 1'b0;
      addr_match <= 1'b0;
      special_flag <= 1'b0;
      pause_flag <= 1'b0;
      rts_hold <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      tx_out <= 1'b1;
      tx_allow <= 1'b0;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
      thre_q <= 1'b1;
      temt_q <= 1'b1;
      reg_rdata <= RST_ZERO;
    end else begin
      interrupt_enable_reg <= next_ier;
      lcr <= next_lcr;
      mcr <= next_mcr;
      scratch_reg <= next_spr;
      enhanced_feature_control <= next_efr;
      sw_flow_resume_char_1 <= next_sw_flow_resume_char_1;
      sw_flow_resume_char_2 <= next_sw_flow_resume_char_2;
      sw_flow_pause_char_1 <= next_sw_flow_pause_char_1;
      sw_flow_pause_char_2 <= next_sw_flow_pause_char_2;
      rx_trig <= next_rx_trig;
      sw_paused <= next_sw_paused;
      addr_match <= next_addr_match;
      special_flag <= next_special_flag;
      pause_flag <= next_pause_flag;
      rts_hold <= next_rts_hold;
      rts_n <= next_rts_n;
      dtr_n <= !mcr[MCR_DTR];
      tx_out <= tx_serial;
      tx_allow <= next_tx_allow;
      int_out <= next_int_out;
      int_oe_n <= next_int_oe_n;
      thre_q <= tx_hold_empty;
      temt_q <= tx_shift_empty;
      reg_rdata <= next_rdata;
    end
  end

  // =========================================================
  // divisor latches: only the power-up reset touches them
  always_comb begin
    next_dll = dll;
    next_dlm = divisor_high_byte;
    if (wr_en && reg_sel == REG_DLL) begin
      next_dll = reg_wdata;
    end
    if (wr_en && reg_sel == REG_DLM) begin
      next_dlm = reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge power_on) begin
    if (power_on) begin
      dll <= RST_DLL;
      divisor_high_byte <= RST_DLM;
      divisor <= {RST_DLM, RST_DLL};
    end else begin
      dll <= next_dll;
      divisor_high_byte <= next_dlm;
      divisor <= {next_dlm, next_dll};
    end
  end
endmodule // uart_flow_ctrl

/* verif/uart_flow_checker.sv */
`timescale 1ns/1ps
module uart_flow_checker
  import uart_flow_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic power_on,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic rx_ready,
  input wire logic tx_allow,
  input wire logic tx_out,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic int_oe_n,
  input wire logic [15:0] divisor
);
  // ==========================================================
  // shadow of the controls that the pin rules depend on
  logic [7:0] efr_q, mcr_q, trig_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      efr_q <= 8'h00;
      mcr_q <= 8'h00;
      trig_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_sel == REG_EFR) efr_q <= reg_wdata;
      if (reg_sel == REG_MCR) mcr_q <= reg_wdata;
      if (reg_sel == REG_TRIG) trig_q <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // assertions
  property p_reset_pins;
    $fell(reset) |-> tx_out && rts_n && dtr_n && int_oe_n;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pin levels wrong after reset");
  property p_allow_after_reset;
    $fell(reset) |=> tx_allow;
  endproperty
  a_allow_after_reset: assert property (p_allow_after_reset) else $error("tx gated after reset");
  property p_rts_sw;
    !efr_q[EFR_AUTO_RTS] && !$past(efr_q[EFR_AUTO_RTS]) |-> rts_n == !$past(mcr_q[MCR_RTS]);
  endproperty
  a_rts_sw: assert property (p_rts_sw) else $error("rts_n not following software");
  property p_int_pin;
    int_oe_n == !$past(mcr_q[MCR_OUT2]) && dtr_n == !$past(mcr_q[MCR_DTR]);
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("int_oe_n or dtr_n wrong");
  property p_cts_stop;
    (efr_q[EFR_AUTO_CTS] && cts_n) [*4] |-> !tx_allow;
  endproperty
  a_cts_stop: assert property (p_cts_stop) else $error("tx allowed while cts high");
  property p_cts_go;
    (efr_q[EFR_AUTO_CTS] && efr_q[1:0] == FLOW_NONE && !cts_n) [*4] |-> tx_allow;
  endproperty
  a_cts_go: assert property (p_cts_go) else $error("tx not resumed on cts low");
  property p_div_keep;
    disable iff (power_on) reset |=> $stable(divisor);
  endproperty
  a_div_keep: assert property (p_div_keep) else $error("divisor changed by reset");
  property p_div_pwr;
    power_on |-> divisor == 16'h0001;
  endproperty
  a_div_pwr: assert property (p_div_pwr) else $error("divisor not 0001 at power-up");
  property p_rts_auto;
    efr_q[EFR_AUTO_RTS] && mcr_q[MCR_RTS] && trig_q inside {[1:3]} && !rx_ready
      |-> ##[0:2] rts_n;
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("rts_n low with full fifo");
endmodule // uart_flow_checker

/* verif/remote_port.sv */
`timescale 1ns/1ps
module remote_port (
  input wire logic mclk,
  input wire logic stall,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_addr_flag
);
  logic [8:0] q[$];
  logic taken = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_addr_flag = 1'b0;
  end
  task automatic send(input logic flag, input logic [7:0] ch);
    q.push_back({flag, ch});
  endtask
  always @(posedge mclk) taken <= rx_valid && rx_ready;
  // a released data line shows the inverse so stale values never match
  always @(negedge mclk) begin
    if (taken || !rx_valid) begin
      if (q.size() > 0 && !stall) begin
        {rx_addr_flag, rx_data} <= q.pop_front();
        rx_valid <= 1'b1;
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule // remote_port

/* verif/test_uart_enhanced_flow_control.sv */
`timescale 1ns/1ps
module test_uart_enhanced_flow_control;
  import uart_flow_pkg::*;
  logic mclk, reset, power_on, reg_wr, reg_rd, reg_rd_seen, stall, tx_serial, tx_out;
  logic cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, int_out, int_oe_n, tx_allow;
  logic rx_valid, rx_addr_flag, rx_ready, tx_hold_empty, tx_shift_empty;
  logic [3:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, rx_data, x2, r2, v, m_v, e_v;
  logic [15:0] divisor;
  logic [15:0] rd_q[$];
  logic [31:0] seed;
  logic [7:0] rst_tab [16] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'hFF, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  int n_errors, compares, cycles;
  uart_flow_ctrl dut (
    .mclk(mclk),
    .reset(reset),
    .power_on(power_on),
    .reg_sel(reg_sel),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_addr_flag(rx_addr_flag),
    .rx_ready(rx_ready),
    .tx_serial(tx_serial),
    .tx_hold_empty(tx_hold_empty),
    .tx_shift_empty(tx_shift_empty),
    .tx_allow(tx_allow),
    .tx_out(tx_out),
    .cts_n(cts_n),
    .dsr_n(dsr_n),
    .ri_n(ri_n),
    .dcd_n(dcd_n),
    .rts_n(rts_n),
    .dtr_n(dtr_n),
    .int_out(int_out),
    .int_oe_n(int_oe_n),
    .divisor(divisor)
  );
  remote_port rp (.mclk, .stall, .rx_ready, .rx_valid, .rx_data, .rx_addr_flag);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // register access: strobes are only ever set once per falling edge
  task automatic acc(input logic w, input logic r, input logic [3:0] sel, input logic [7:0] d);
    reg_wr = w;
    reg_rd = r;
    reg_sel = sel;
    reg_wdata = d;
    @(negedge mclk);
  endtask
  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    acc(1'b1, 1'b0, sel, d);
  endtask
  task automatic rd(input logic [3:0] sel, input logic [7:0] exp, input logic [7:0] m);
    rd_q.push_back({m, exp});
    acc(1'b0, 1'b1, sel, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) acc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic drain();
    for (int j = 0; j < 60 && (rp.q.size() > 0 || rp.rx_valid); j++) idle(1);
    idle(2);
  endtask
  // read data lands one edge after the strobe
  always @(posedge mclk) begin
    cycles++;
    if (reg_rd_seen) begin
      {m_v, e_v} = rd_q.pop_front();
      check("reg_rdata", 16'(reg_rdata & m_v), 16'(e_v & m_v));
    end
    reg_rd_seen <= reg_rd;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end
  always @(negedge mclk) tx_serial <= seed[0];
  // ==========================================================
  // scenarios
  initial begin
    {reset, power_on, reg_wr, reg_rd, reg_rd_seen, stall} = 6'b110000;
    {cts_n, dsr_n, ri_n, dcd_n, tx_serial, tx_hold_empty, tx_shift_empty} = 7'h7F;
    reg_sel = 4'h0;
    reg_wdata = 8'h00;
    seed = 32'h327e_77a0;
    {n_errors, compares, cycles} = '0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    power_on = 1'b0;
    for (int i = 0; i < 16; i++) rd(4'(i), rst_tab[i], 8'hFF);
    check("pins", 16'({rts_n, dtr_n, int_oe_n, tx_allow}), 16'h000F);
    v = rnd();
    wr(REG_SPR, v);
    wr(REG_DLL, v ^ 8'h5A);
    wr(REG_DLM, v);
    wr(REG_ISR, 8'hFF);
    rd(REG_SPR, v, 8'hFF);
    rd(REG_ISR, 8'h01, 8'hFF);
    // let the pending read data be checked before reset clears it
    idle(1);
    reset = 1'b1;
    idle(1);
    check("reset_pins", 16'({tx_out, rts_n, dtr_n, int_oe_n, int_out, rx_ready}), 16'h003D);
    idle(1);
    reset = 1'b0;
    {cts_n, dsr_n, ri_n, dcd_n} = 4'h0;
    idle(3);
    check("divisor", divisor, {v, v ^ 8'h5A});
    rd(REG_SPR, 8'hFF, 8'hFF);
    rd(REG_MSR, 8'hF0, 8'hFF);
    // odd value below 0x80 so its bit-reversal can never match
    x2 = (rnd() | 8'h41) & 8'h7F;
    r2 = {<<{x2}};
    wr(REG_SW_FLOW_PAUSE_CHAR_2, x2);
    wr(REG_SW_FLOW_RESUME_CHAR_1, 8'h11);
    wr(REG_SW_FLOW_PAUSE_CHAR_1, 8'h13);
    wr(REG_EFR, 8'h20);
    rp.send(1'b0, r2);
    drain();
    rd(REG_ISR, 8'h00, 8'h10);
    rp.send(1'b0, x2);
    drain();
    rd(REG_ISR, 8'h10, 8'h10);
    rd(REG_RXDATA, r2, 8'hFF);
    rd(REG_RXDATA, x2, 8'hFF);
    wr(REG_EFR, 8'h00);
    wr(REG_EFR, 8'h22);
    rp.send(1'b0, 8'h13);
    rp.send(1'b0, x2);
    drain();
    check("tx_allow", 16'(tx_allow), 16'h0000);
    rd(REG_ISR, 8'h10, 8'h10);
    rd(REG_RXDATA, x2, 8'hFF);
    rd(REG_RXDATA, 8'h00, 8'hFF);
    rp.send(1'b0, 8'h11);
    drain();
    check("tx_allow", 16'(tx_allow), 16'h0001);
    wr(REG_EFR, 8'h00);
    wr(REG_EFR, 8'h10);
    wr(REG_IER, 8'h20);
    wr(REG_EFR, 8'h00);
    wr(REG_EFR, 8'h21);
    rp.send(1'b0, x2);
    drain();
    check("int_out", 16'(int_out), 16'h0001);
    rd(REG_ISR, 8'h30, 8'h30);
    rd(REG_RXDATA, 8'h00, 8'hFF);
    wr(REG_EFR, 8'h00);
    wr(REG_EFR, 8'h10);
    wr(REG_MCR, 8'h40);
    rp.send(1'b1, x2 ^ 8'h01);
    rp.send(1'b0, 8'hA5);
    rp.send(1'b1, x2);
    rp.send(1'b0, 8'h5A);
    drain();
    rd(REG_RXDATA, 8'h5A, 8'hFF);
    rd(REG_RXDATA, 8'h00, 8'hFF);
    wr(REG_MCR, 8'h00);
    wr(REG_EFR, 8'h00);
    wr(REG_EFR, 8'h40);
    wr(REG_TRIG, 8'h02);
    wr(REG_IER, 8'h01);
    wr(REG_MCR, 8'h02);
    stall = 1'b1;
    for (int i = 1; i < 6; i++) rp.send(1'b0, 8'(i));
    idle(3);
    stall = 1'b0;
    for (int j = 0; j < 40 && rx_ready; j++) idle(1);
    idle(2);
    check("fill", 16'({rx_ready, rts_n, int_out}), 16'h0003);
    rd(REG_RXDATA, 8'h01, 8'hFF);
    idle(2);
    for (int i = 2; i < 5; i++) rd(REG_RXDATA, 8'(i), 8'hFF);
    idle(2);
    check("rts_n", 16'(rts_n), 16'h0001);
    rd(REG_RXDATA, 8'h05, 8'hFF);
    idle(3);
    check("drained", 16'({rx_ready, rts_n}), 16'h0002);
    wr(REG_EFR, 8'h00);
    wr(REG_MCR, 8'h0B);
    idle(2);
    check("pins", 16'({rts_n, dtr_n, int_oe_n}), 16'h0000);
    wr(REG_EFR, 8'h80);
    cts_n = 1'b1;
    idle(5);
    check("tx_allow", 16'(tx_allow), 16'h0000);
    cts_n = 1'b0;
    idle(5);
    check("tx_allow", 16'(tx_allow), 16'h0001);
    results();
  end
endmodule // test_uart_enhanced_flow_control
bind uart_flow_ctrl uart_flow_checker chk (.mclk(mclk), .reset(reset), .power_on(power_on),
  .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .rx_ready(rx_ready),
  .tx_allow(tx_allow), .tx_out(tx_out), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n),
  .int_oe_n(int_oe_n), .divisor(divisor));
